// *** verilog/sac_defines.svh ***
// Constants for the converter sequencer and result registers
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH
// -----------------------------------------------------------------
// Addresses
// -----------------------------------------------------------------
`define SAC_ADDR_MODE 16'hFF2A
`define SAC_ADDR_RES_LO 16'hFF18
`define SAC_ADDR_RES_HI 16'hFF19
`define SAC_ADDR_RES_HB 16'hFF1F
`define SAC_ADDR_CHAN 16'hFF2B
`define SAC_ADDR_PINCFG 16'hFF22
// -----------------------------------------------------------------
// Mode register fields
// -----------------------------------------------------------------
`define SAC_BIT_RUN 7
`define SAC_BIT_CMP 0
`define SAC_TSEL_HI 5
`define SAC_TSEL_LO 3
`define SAC_RSEL_HI 2
`define SAC_RSEL_LO 1
`define SAC_MODE_WMASK 8'hBF
`define SAC_RST_MODE 8'h00
`define SAC_RST_WIDE 16'h0000
`define SAC_RST_BYTE 8'h00
// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define SAC_STEP_DIV 9'h00B
`define SAC_NSTEPS 9'h00A
`define SAC_MSB_IDX 4'h9
`define SAC_SAR_MID 10'h200
// Conversion lengths in clock cycles, normal range
`define SAC_CYC_N0 9'h108
`define SAC_CYC_N1 9'h0B0
`define SAC_CYC_N2 9'h084
`define SAC_CYC_N3 9'h058
`define SAC_CYC_N4 9'h042
`define SAC_CYC_N5 9'h02C
// Conversion lengths in clock cycles, low reference range
`define SAC_CYC_L0 9'h1E0
`define SAC_CYC_L1 9'h140
`define SAC_CYC_L2 9'h0F0
`define SAC_CYC_L3 9'h0A0
`define SAC_CYC_L4 9'h078
// Longest valid setting, used for prohibited codes
`define SAC_CYC_SLOWEST 9'h1E0
`endif

// *** verilog/sac_pkg.sv ***
// Types for the converter sequencer
`default_nettype none
package sac_pkg;
  typedef enum logic [1:0] {SAC_IDLE, SAC_SAMPLE, SAC_RESOLVE} sac_state_t;
endpackage
`default_nettype wire

// *** verilog/sac_if.sv ***
// Result-load handshake between sequencer and result store
`timescale 1ns/10ps
`default_nettype none
interface sac_if;
  logic load;
  logic [9:0] value;
  logic clear;
  modport seq (output load, output value, output clear);
  modport store (input load, input value, input clear);
endinterface
`default_nettype wire

// *** verilog/sac_result_store.sv ***
// Result registers holding the finished conversion value
`timescale 1ns/10ps
`default_nettype none
`include "sac_defines.svh"
module sac_result_store
  import sac_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  sac_if.store res,
  output logic [15:0] wide,
  output logic [7:0] high_byte
);
  logic [15:0] next_wide;
  logic [7:0] next_high_byte;

  // Left-justified load, low six bits zero
  always_comb begin
    next_wide = wide;
    next_high_byte = high_byte;
    if (res.clear) begin
      next_wide = `SAC_RST_WIDE;
      next_high_byte = `SAC_RST_BYTE;
    end
    if (res.load) begin
      next_wide = {res.value, 6'h00};
      next_high_byte = res.value[9:2];
    end
  end

  // Reset clears both results
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      wide <= `SAC_RST_WIDE;
      high_byte <= `SAC_RST_BYTE;
    end else begin
      wide <= next_wide;
      high_byte <= next_high_byte;
    end
  end
endmodule
`default_nettype wire

// *** verilog/sac_converter.sv ***
// Successive-approximation converter sequencer with mode and result registers
`timescale 1ns/10ps
`default_nettype none
`include "sac_defines.svh"
module sac_converter
  import sac_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic [15:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic WIDE_ACCESS,
  input wire logic [7:0] WDATA,
  input wire logic CMP_RESULT,
  output logic [15:0] RDATA,
  output logic WAIT_CYCLE,
  output logic COMPARATOR_ON,
  output logic SAMPLE_HOLD,
  output logic [9:0] DAC_CODE,
  output logic CONVERSION_DONE_IRQ,
  output logic FIRST_RESULT_INVALID
);
  sac_if res_link();
  sac_state_t state, next_state;
  logic [7:0] converter_mode_reg, next_mode;
  logic [8:0] cyc_cnt, next_cyc_cnt;
  logic [3:0] bit_idx, next_bit_idx;
  logic [9:0] sar, next_sar;
  logic first_pending, next_first_pending;
  logic [15:0] next_rdata;
  logic next_wait, next_irq, next_invalid;
  logic next_cmp_on, next_sample_hold;
  logic [15:0] wide;
  logic [7:0] high_byte;
  logic [8:0] total_cycles;
  logic [8:0] step_cycles;
  logic conv_run;
  logic mode_wr;

  // -----------------------------------------------------------------
  // Timing table
  // -----------------------------------------------------------------
  // Cycle count from time and range codes
  function automatic logic [8:0] conv_cycles(input logic [2:0] tsel, input logic [1:0] rsel);
    logic [8:0] c;
    c = `SAC_CYC_SLOWEST;
    if (rsel == 2'b00) begin
      case (tsel)
        3'b000: c = `SAC_CYC_N0;
        3'b001: c = `SAC_CYC_N1;
        3'b010: c = `SAC_CYC_N2;
        3'b011: c = `SAC_CYC_N3;
        3'b100: c = `SAC_CYC_N4;
        3'b101: c = `SAC_CYC_N5;
        default: c = `SAC_CYC_SLOWEST;
      endcase
    end else if (rsel == 2'b01) begin
      case (tsel)
        3'b000: c = `SAC_CYC_L0;
        3'b001: c = `SAC_CYC_L1;
        3'b010: c = `SAC_CYC_L2;
        3'b011: c = `SAC_CYC_L3;
        3'b100: c = `SAC_CYC_L4;
        default: c = `SAC_CYC_SLOWEST;
      endcase
    end else begin
      c = `SAC_CYC_SLOWEST;
    end
    return c;
  endfunction

  assign conv_run = converter_mode_reg[`SAC_BIT_RUN];
  assign total_cycles = conv_cycles(converter_mode_reg[`SAC_TSEL_HI:`SAC_TSEL_LO],
                                    converter_mode_reg[`SAC_RSEL_HI:`SAC_RSEL_LO]);
  // Per-bit time; remainder absorbed by sampling
  assign step_cycles = total_cycles / `SAC_STEP_DIV;
  assign mode_wr = WR_EN && (ADDR == `SAC_ADDR_MODE);

  // -----------------------------------------------------------------
  // Mode register and bus
  // -----------------------------------------------------------------
  // Register writes and read data
  always_comb begin
    next_mode = converter_mode_reg;
    next_rdata = RDATA;
    next_wait = 1'b0;
    if (mode_wr) begin
      next_mode = WDATA & `SAC_MODE_WMASK;
    end
    next_cmp_on = next_mode[`SAC_BIT_CMP];
    if (mode_wr) begin
      next_wait = 1'b1;
    end
    if (RD_EN) begin
      next_rdata = 16'h0000;
      case (ADDR)
        `SAC_ADDR_RES_LO: begin
          next_rdata = WIDE_ACCESS ? wide : 16'h0000;
          next_wait = 1'b1;
        end
        `SAC_ADDR_RES_HI: begin
          next_rdata = {8'h00, wide[15:8]};
          next_wait = 1'b1;
        end
        `SAC_ADDR_RES_HB: begin
          next_rdata = {8'h00, high_byte};
          next_wait = 1'b1;
        end
        `SAC_ADDR_MODE: next_rdata = {8'h00, converter_mode_reg};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------
  // Sampling then bitwise resolution
  always_comb begin
    next_state = state;
    next_cyc_cnt = cyc_cnt;
    next_bit_idx = bit_idx;
    next_sar = sar;
    next_first_pending = first_pending;
    next_irq = 1'b0;
    next_invalid = FIRST_RESULT_INVALID;
    res_link.load = 1'b0;
    res_link.value = sar;
    res_link.clear = mode_wr || (WR_EN && (ADDR == `SAC_ADDR_CHAN ||
                                           ADDR == `SAC_ADDR_PINCFG));
    case (state)
      SAC_IDLE: begin
        if (conv_run) begin
          next_state = SAC_SAMPLE;
          next_cyc_cnt = 9'd0;
          next_first_pending = !converter_mode_reg[`SAC_BIT_CMP];
        end
      end
      SAC_SAMPLE: begin
        next_cyc_cnt = cyc_cnt + 9'd1;
        if (cyc_cnt + 9'd1 >= total_cycles - step_cycles * `SAC_NSTEPS) begin
          next_state = SAC_RESOLVE;
          next_cyc_cnt = 9'd0;
          next_bit_idx = `SAC_MSB_IDX;
          next_sar = `SAC_SAR_MID;
        end
      end
      SAC_RESOLVE: begin
        next_cyc_cnt = cyc_cnt + 9'd1;
        if (cyc_cnt + 9'd1 >= step_cycles) begin
          next_cyc_cnt = 9'd0;
          // keep or drop trial bit, MSB first
          next_sar[bit_idx] = CMP_RESULT;
          if (bit_idx != 4'd0) begin
            next_sar[bit_idx - 4'd1] = 1'b1;
            next_bit_idx = bit_idx - 4'd1;
          end else begin
            res_link.load = 1'b1;
            res_link.value = {sar[9:1], CMP_RESULT};
            next_irq = 1'b1;
            next_invalid = first_pending;
            next_first_pending = 1'b0;
            next_state = SAC_SAMPLE;
          end
        end
      end
      default: next_state = SAC_IDLE;
    endcase
    if (!conv_run) begin
      next_state = SAC_IDLE;
      next_cyc_cnt = 9'd0;
    end
    next_sample_hold = (next_state == SAC_SAMPLE);
  end

  // Register all state
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      state <= SAC_IDLE;
      converter_mode_reg <= `SAC_RST_MODE;
      cyc_cnt <= 9'd0;
      bit_idx <= 4'd0;
      sar <= 10'h000;
      first_pending <= 1'b0;
      RDATA <= 16'h0000;
      WAIT_CYCLE <= 1'b0;
      COMPARATOR_ON <= 1'b0;
      SAMPLE_HOLD <= 1'b0;
      DAC_CODE <= 10'h000;
      CONVERSION_DONE_IRQ <= 1'b0;
      FIRST_RESULT_INVALID <= 1'b0;
    end else begin
      state <= next_state;
      converter_mode_reg <= next_mode;
      cyc_cnt <= next_cyc_cnt;
      bit_idx <= next_bit_idx;
      sar <= next_sar;
      first_pending <= next_first_pending;
      RDATA <= next_rdata;
      WAIT_CYCLE <= next_wait;
      COMPARATOR_ON <= next_cmp_on;
      SAMPLE_HOLD <= next_sample_hold;
      DAC_CODE <= next_sar;
      CONVERSION_DONE_IRQ <= next_irq;
      FIRST_RESULT_INVALID <= next_invalid;
    end
  end

  sac_result_store i_sac_result_store (
    .CLK_SYS(CLK_SYS),
    .RST_B(RST_B),
    .res(res_link.store),
    .wide(wide),
    .high_byte(high_byte)
  );
endmodule
`default_nettype wire

// *** dv/sac_converter_checker.sv ***
// Port checker for the converter sequencer and result registers
`timescale 1ns/10ps
`default_nettype none
module sac_converter_checker (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic [15:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic WIDE_ACCESS,
  input wire logic [7:0] WDATA,
  input wire logic CMP_RESULT,
  input wire logic [15:0] RDATA,
  input wire logic WAIT_CYCLE,
  input wire logic COMPARATOR_ON,
  input wire logic SAMPLE_HOLD,
  input wire logic [9:0] DAC_CODE,
  input wire logic CONVERSION_DONE_IRQ,
  input wire logic FIRST_RESULT_INVALID
);
  default clocking dc @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);
  AST_WAIT: assert property (
    (WR_EN && ADDR == 16'hFF2A) || (RD_EN && (ADDR == 16'hFF18 || ADDR == 16'hFF19 ||
    ADDR == 16'hFF1F)) |=> WAIT_CYCLE) else $error("wait cycle missing");
  AST_NO_WAIT: assert property (
    !WR_EN && !RD_EN |=> !WAIT_CYCLE) else $error("wait cycle without access");
  AST_CMP_BIT: assert property (
    WR_EN && ADDR == 16'hFF2A |=> COMPARATOR_ON == $past(WDATA[0])) else $error("comparator bit");
  AST_STOP: assert property (
    WR_EN && ADDR == 16'hFF2A && !WDATA[7] |=> ##1 !CONVERSION_DONE_IRQ [*8])
    else $error("done pulse after stop");
  AST_LOW_ZERO: assert property (
    RD_EN && WIDE_ACCESS && ADDR == 16'hFF18 |=> RDATA[5:0] == 6'h00) else $error("low bits set");
  AST_HOLD: assert property (
    !RD_EN |=> $stable(RDATA)) else $error("read data moved");
  AST_IRQ_GAP: assert property (
    CONVERSION_DONE_IRQ |=> !CONVERSION_DONE_IRQ [*8]) else $error("done pulses too close");
  AST_INVALID: assert property (
    $changed(FIRST_RESULT_INVALID) |-> CONVERSION_DONE_IRQ) else $error("invalid flag moved");
  AST_SAMPLE_START: assert property (
    CONVERSION_DONE_IRQ |-> SAMPLE_HOLD) else $error("no sampling after done");
  AST_STOP_SAMPLE: assert property (
    WR_EN && ADDR == 16'hFF2A && !WDATA[7] |=> ##1 !SAMPLE_HOLD)
    else $error("sampling after stop");
endmodule
bind sac_converter sac_converter_checker i_sac_converter_checker (.CLK_SYS(CLK_SYS),
  .RST_B(RST_B), .ADDR(ADDR), .WR_EN(WR_EN), .RD_EN(RD_EN), .WIDE_ACCESS(WIDE_ACCESS),
  .WDATA(WDATA), .CMP_RESULT(CMP_RESULT), .RDATA(RDATA), .WAIT_CYCLE(WAIT_CYCLE),
  .COMPARATOR_ON(COMPARATOR_ON), .SAMPLE_HOLD(SAMPLE_HOLD), .DAC_CODE(DAC_CODE),
  .CONVERSION_DONE_IRQ(CONVERSION_DONE_IRQ), .FIRST_RESULT_INVALID(FIRST_RESULT_INVALID));
`default_nettype wire

// *** dv/test_sac_converter.sv ***
// Self-checking testbench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module test_sac_converter;
  logic CLK_SYS = 1'b0;
  logic RST_B = 1'b0;
  logic [15:0] ADDR = 16'h0000;
  logic WR_EN = 1'b0;
  logic RD_EN = 1'b0;
  logic WIDE_ACCESS = 1'b0;
  logic [7:0] WDATA = 8'h00;
  logic CMP_RESULT = 1'b0;
  logic [15:0] RDATA;
  logic WAIT_CYCLE, COMPARATOR_ON, SAMPLE_HOLD, CONVERSION_DONE_IRQ, FIRST_RESULT_INVALID;
  logic [9:0] DAC_CODE;
  logic [9:0] target = 10'h2A5;
  logic [15:0] rv;
  logic [7:0] mtab [13] = '{8'h81, 8'h89, 8'h91, 8'h99, 8'hA1, 8'hA9, 8'h83, 8'h8B, 8'h93,
    8'h9B, 8'hA3, 8'hB9, 8'hAB};
  int ctab [13] = '{264, 176, 132, 88, 66, 44, 480, 320, 240, 160, 120, 480, 480};
  int err_count = 0;
  int checked = 0;
  int n;
  sac_converter i_sac_converter (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .ADDR(ADDR), .WR_EN(WR_EN),
    .RD_EN(RD_EN), .WIDE_ACCESS(WIDE_ACCESS), .WDATA(WDATA), .CMP_RESULT(CMP_RESULT),
    .RDATA(RDATA), .WAIT_CYCLE(WAIT_CYCLE), .COMPARATOR_ON(COMPARATOR_ON),
    .SAMPLE_HOLD(SAMPLE_HOLD), .DAC_CODE(DAC_CODE), .CONVERSION_DONE_IRQ(CONVERSION_DONE_IRQ),
    .FIRST_RESULT_INVALID(FIRST_RESULT_INVALID));
  // Clock
  initial begin
    forever #25 CLK_SYS = ~CLK_SYS;
  end
  // Comparator keeps trial bits not above the input
  always @(posedge CLK_SYS) begin
    #1;
    CMP_RESULT = (DAC_CODE <= target);
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("mismatches=%0d comparisons=%0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    #1;
    ADDR = a;
    WDATA = d;
    WR_EN = 1'b1;
    @(posedge CLK_SYS);
    #1;
    WR_EN = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic w);
    @(posedge CLK_SYS);
    #1;
    ADDR = a;
    WIDE_ACCESS = w;
    RD_EN = 1'b1;
    @(posedge CLK_SYS);
    #1;
    RD_EN = 1'b0;
    rv = RDATA;
  endtask
  // Cycles up to the next done pulse, bounded
  task automatic wait_irq;
    n = 0;
    do begin
      @(posedge CLK_SYS);
      #1;
      n++;
    end while (CONVERSION_DONE_IRQ !== 1'b1 && n < 1000);
    if (CONVERSION_DONE_IRQ !== 1'b1) begin
      chk({15'h0000, CONVERSION_DONE_IRQ}, 16'h0001);
      end_of_test();
    end
  endtask
  task automatic t_reset;
    rd(16'hFF18, 1'b1);
    chk(rv, 16'h0000);
    rd(16'hFF1F, 1'b0);
    chk(rv, 16'h0000);
    rd(16'h1234, 1'b1);
    chk(rv, 16'h0000);
  endtask
  task automatic t_modes;
    wr(16'hFF2A, 8'h01);
    chk({15'h0000, COMPARATOR_ON}, 16'h0001);
    n = 0;
    repeat (300) begin
      @(posedge CLK_SYS);
      #1;
      if (CONVERSION_DONE_IRQ !== 1'b0) n++;
    end
    chk(16'(n), 16'h0000);
    chk({15'h0000, SAMPLE_HOLD}, 16'h0000);
    wr(16'hFF2A, 8'h40);
    chk({15'h0000, COMPARATOR_ON}, 16'h0000);
    rd(16'hFF2A, 1'b0);
    chk(rv, 16'h0000);
  endtask
  task automatic t_times;
    for (int i = 0; i < 13; i++) begin
      wr(16'hFF2A, mtab[i] & 8'h7F);
      repeat (20) @(posedge CLK_SYS);
      wr(16'hFF2A, mtab[i]);
      wait_irq();
      wait_irq();
      chk(16'(n), 16'(ctab[i]));
      wr(16'hFF2A, mtab[i] & 8'h7F);
    end
  endtask
  task automatic t_result;
    wr(16'hFF2A, 8'h11);
    // divide by twelve keeps clock in band
    wr(16'hFF2A, 8'h91);
    wait_irq();
    rd(16'hFF18, 1'b1);
    chk(rv, {target, 6'h00});
    rd(16'hFF19, 1'b0);
    chk(rv, {8'h00, target[9:2]});
    rd(16'hFF1F, 1'b0);
    chk(rv, {8'h00, target[9:2]});
    rd(16'hFF18, 1'b0);
    chk(rv, 16'h0000);
    wr(16'hFF2B, 8'h00);
    rd(16'hFF18, 1'b1);
    chk(rv, 16'h0000);
    wr(16'hFF2A, 8'h11);
  endtask
  task automatic t_nocmp;
    wr(16'hFF2A, 8'h10);
    wr(16'hFF2A, 8'h90);
    wait_irq();
    @(posedge CLK_SYS);
    #1;
    chk({15'h0000, FIRST_RESULT_INVALID}, 16'h0001);
    chk({15'h0000, COMPARATOR_ON}, 16'h0000);
    wait_irq();
    @(posedge CLK_SYS);
    #1;
    chk({15'h0000, FIRST_RESULT_INVALID}, 16'h0000);
    wr(16'hFF2A, 8'h10);
  endtask
  initial begin
    repeat (12) @(posedge CLK_SYS);
    #1;
    RST_B = 1'b1;
    t_reset();
    t_modes();
    t_times();
    t_result();
    t_nocmp();
    end_of_test();
  end
endmodule
`default_nettype wire
